//--- verilog/ftwac_tag_alias.v
// Live tag word, stack top and SIMD alias control with an AXI4-Lite slave.
// Assumes a core issuing one op per cmd_valid pulse, with register values
// supplied on fp_reg_val and the saved tag image on mem_tag_in.
// Timing overview
// - A command is taken on a rising edge where clk_en and cmd_valid are high.
// - cmd_done and cmd_exc answer on that same edge and stand for one cycle.
// - Pulse outputs (image write, save, load, vector) share that cycle.
// - live_tags and stack_top trail the internal word by one more cycle,
//   so a consumer sees the new tags two edges after the command.
// - Back-to-back commands are legal; each sees the word left by the last.
//
// Exceptions
// - Only SIMD-class ops are screened; ordinary FP and save or restore
//   ops never fault here, their faults belong to other logic.
// - Priority is emulation, task switch, pending error, memory.
// - A faulted op has no effect on tags, top or register writes, so the
//   core may simply reissue it once the handler has run.
//
// Register bus
// - Write address and data are latched in either order; the response
//   follows one cycle after both are held.
// - The tag word is read-only; a write to it answers with an error.
// - Status bits are sticky and cleared by writing ones; an event in the
//   same cycle as its clear keeps the bit set, so no event is lost.
// - irq is registered and trails the status word by one cycle.
//
// Limitations
// - Register classification is combinational over all eight values,
//   which costs area but keeps save and restore single-cycle.
// - clk_en low freezes every flop, bus handshakes included.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ftwac_consts.vh"
module ftwac_tag_alias (
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  // Core command port
  input wire cmd_valid,
  input wire [3:0] cmd_op,
  input wire [7:0] cmd_mod_mask,
  input wire [7:0] cmd_mod_empty,
  input wire cmd_simd_wr,
  input wire [2:0] cmd_simd_reg,
  input wire [63:0] cmd_simd_data,
  input wire cmd_mem_fault,
  input wire cmd_misaligned,
  input wire fp_err_pending,
  input wire fp_flags_in_use,
  // Physical register contents, eight by 80 bits
  input wire [639:0] fp_reg_val,
  // Saved tag image from memory
  input wire [15:0] mem_tag_in,
  // Results to core and memory
  output reg cmd_done,
  output reg [2:0] cmd_exc,
  output reg fp_flags_touch,
  output reg mem_tag_we,
  output reg [15:0] mem_tag_out,
  output reg state_save_req,
  output reg state_load_req,
  output reg vec_state_req,
  output reg [15:0] live_tags,
  output reg [2:0] stack_top,
  output reg reg_wr_en,
  output reg [2:0] reg_wr_idx,
  output reg [79:0] reg_wr_data,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt
  output reg irq
);

  // Exponent all clear or all set, or a clear integer bit, counts as
  // special; only a clear exponent with a clear fraction is zero.
  // The sign bit plays no part in the class.
  // Classify one 80-bit register: zero, special or nonzero
  function [1:0] ftwac_classify;
    input [79:0] v;
    begin
      if (v[78:64] == 15'h0000 && v[63:0] == 64'h0000000000000000) begin
        ftwac_classify = `FTWAC_TAG_ZERO;
      end else if (v[78:64] == 15'h7FFF || v[78:64] == 15'h0000 || !v[63]) begin
        ftwac_classify = `FTWAC_TAG_SPECIAL;
      end else begin
        ftwac_classify = `FTWAC_TAG_VALID;
      end
    end
  endfunction

  // Control, status and mask live here; the tag word and top are
  // shared with the command path and read back on the bus.
  // Software registers
  reg [2:0] ctrl_r; // Emulation, task switched, alignment check
  reg [4:0] stat_r; // Sticky events
  reg [4:0] mask_r; // Interrupt mask
  reg [15:0] tags_r; // Live tag word
  reg [2:0] top_r;
  // Write channel latches, taken in either order
  reg aw_got_r;
  reg w_got_r;
  reg [3:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  // One classifier per physical register; the save path looks at the
  // live empty marks, the restore path at the marks of the image.
  // Both results are ready every cycle, whichever op comes.
  // Per-field next tags for save and restore
  wire [15:0] saved_img; // Computed image
  wire [15:0] restored; // Recomputed live tags
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_tag
      wire [1:0] cls;
      assign cls = ftwac_classify(fp_reg_val[gi*80 +: 80]);
      assign saved_img[gi*2 +: 2] = (tags_r[gi*2 +: 2] == `FTWAC_TAG_EMPTY) ?
        `FTWAC_TAG_EMPTY : cls;
      assign restored[gi*2 +: 2] = (mem_tag_in[gi*2 +: 2] == `FTWAC_TAG_EMPTY) ?
        `FTWAC_TAG_EMPTY : cls;
    end
  endgenerate

  // FP op next tags: only modified fields change
  reg [15:0] fp_tags;
  integer k;
  always @* begin
    fp_tags = tags_r;
    for (k = 0; k < 8; k = k + 1) begin
      if (cmd_mod_mask[k]) begin
        fp_tags[k*2 +: 2] = cmd_mod_empty[k] ? `FTWAC_TAG_EMPTY : `FTWAC_TAG_VALID;
      end
    end
  end

  // Unknown op codes fall through every class and leave state alone,
  // apart from the done pulse and the fp_flags_touch pulse.
  // Op class decode
  wire is_simd = (cmd_op == `FTWAC_OP_SIMD) || (cmd_op == `FTWAC_OP_CLEAR);
  wire is_save = (cmd_op == `FTWAC_OP_SAVE) || (cmd_op == `FTWAC_OP_SAVE_NW) ||
    (cmd_op == `FTWAC_OP_ENV_ST) || (cmd_op == `FTWAC_OP_XSAVE);
  wire is_rest = (cmd_op == `FTWAC_OP_RESTORE) || (cmd_op == `FTWAC_OP_ENV_LD) ||
    (cmd_op == `FTWAC_OP_XRESTORE);
  wire is_vec = (cmd_op == `FTWAC_OP_XSAVE) || (cmd_op == `FTWAC_OP_XRESTORE);

  // Control bits are read from the registered copy, so a bus write
  // takes effect on ops issued after its response.
  // Alignment faults are only reported while checking is enabled.
  // SIMD exception priority: emulation, task switch, pending error, memory
  reg [2:0] exc_sel;
  always @* begin
    exc_sel = `FTWAC_EXC_NONE;
    if (is_simd) begin
      if (ctrl_r[`FTWAC_CTRL_EM]) begin
        exc_sel = `FTWAC_EXC_UD;
      end else if (ctrl_r[`FTWAC_CTRL_TS]) begin
        exc_sel = `FTWAC_EXC_NM;
      end else if (fp_err_pending) begin
        exc_sel = `FTWAC_EXC_MF;
      end else if (cmd_mem_fault || (cmd_misaligned && ctrl_r[`FTWAC_CTRL_AC])) begin
        exc_sel = `FTWAC_EXC_MEM;
      end
    end
  end

  // Events fire on the taking edge, so status leads cmd_done by nothing
  // and irq follows one cycle later.
  // Event pulses for status
  wire cmd_go = clk_en && cmd_valid;
  wire [4:0] ev;
  assign ev[0] = cmd_go && exc_sel == `FTWAC_EXC_UD;
  assign ev[1] = cmd_go && exc_sel == `FTWAC_EXC_NM;
  assign ev[2] = cmd_go && exc_sel == `FTWAC_EXC_MF;
  assign ev[3] = cmd_go && exc_sel == `FTWAC_EXC_MEM;
  assign ev[4] = cmd_go && is_save;

  // All command outputs are flops. Pulses fall back low every enabled
  // cycle; held values (image, write index and data) keep their last
  // contents so a slow consumer can still read them.
  // The tag word is rewritten whole in one edge, never field by field
  // except for the ordinary FP op mask.
  // Command execution
  always @(posedge aclk) begin
    if (!aresetn) begin
      tags_r <= `FTWAC_TAGS_RST;
      top_r <= `FTWAC_TOP_RST;
      cmd_done <= 1'b0;
      cmd_exc <= `FTWAC_EXC_NONE;
      fp_flags_touch <= 1'b0;
      mem_tag_we <= 1'b0;
      mem_tag_out <= 16'h0000;
      state_save_req <= 1'b0;
      state_load_req <= 1'b0;
      vec_state_req <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_wr_idx <= 3'h0;
      reg_wr_data <= 80'h0;
      live_tags <= `FTWAC_TAGS_RST;
      stack_top <= `FTWAC_TOP_RST;
    end else if (clk_en) begin
      // Pulses default low
      cmd_done <= cmd_valid;
      cmd_exc <= cmd_valid ? exc_sel : `FTWAC_EXC_NONE;
      mem_tag_we <= 1'b0;
      state_save_req <= 1'b0;
      state_load_req <= 1'b0;
      vec_state_req <= 1'b0;
      reg_wr_en <= 1'b0;
      // SIMD ops never report flag changes
      fp_flags_touch <= cmd_valid && !is_simd && fp_flags_in_use;
      if (cmd_valid) begin
        if (is_simd && exc_sel == `FTWAC_EXC_NONE) begin
          // A faulted SIMD op leaves state alone; a retried one after the
          // error handler returns lands here with full effect
          top_r <= 3'h0;
          // Tags never gate SIMD data
          tags_r <= (cmd_op == `FTWAC_OP_CLEAR) ? `FTWAC_TAGS_RST : 16'h0000;
          if (cmd_op == `FTWAC_OP_SIMD && cmd_simd_wr) begin
            reg_wr_en <= 1'b1;
            reg_wr_idx <= cmd_simd_reg;
            reg_wr_data <= {`FTWAC_EXP_ONES, cmd_simd_data};
          end
        end else if (is_save) begin
          mem_tag_we <= 1'b1;
          mem_tag_out <= saved_img;
          state_save_req <= cmd_op != `FTWAC_OP_ENV_ST;
          vec_state_req <= is_vec;
          tags_r <= `FTWAC_TAGS_RST;
        end else if (is_rest) begin
          tags_r <= restored;
          state_load_req <= cmd_op != `FTWAC_OP_ENV_LD;
          vec_state_req <= is_vec;
        end else if (cmd_op == `FTWAC_OP_FP) begin
          tags_r <= fp_tags;
        end
      end
      live_tags <= tags_r;
      stack_top <= top_r;
    end
  end

  // Ready is a one-cycle pulse after valid is seen, which costs a cycle
  // per beat but keeps the slave free of combinational paths from the
  // master. Only the low strobe matters, as every field fits one byte.
  // A new address or data beat can be latched while a response is pending;
  // it commits only once bvalid has dropped.
  // AXI4-Lite write path: latch address and data independently
  wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  wire wr_ok = (aw_addr_r == `FTWAC_A_CTRL) || (aw_addr_r == `FTWAC_A_STAT) ||
    (aw_addr_r == `FTWAC_A_MASK) || (aw_addr_r == `FTWAC_A_TAGS);
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FTWAC_AXI_OKAY;
      ctrl_r <= 3'h0;
      mask_r <= 5'h00;
      stat_r <= 5'h00;
      irq <= 1'b0;
    end else if (clk_en) begin
      // Ready pulses one cycle when a slot is free
      s_axi_awready <= !aw_got_r && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_got_r && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      // Commit and respond; tag word is read-only, reports error
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ok && aw_addr_r != `FTWAC_A_TAGS) ? `FTWAC_AXI_OKAY :
          `FTWAC_AXI_SLVERR;
        if (aw_addr_r == `FTWAC_A_CTRL && w_strb_r[0]) begin
          ctrl_r <= w_data_r[2:0];
        end
        if (aw_addr_r == `FTWAC_A_MASK && w_strb_r[0]) begin
          mask_r <= w_data_r[4:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Sticky status: a new event wins over a write-one clear
      if (wr_fire && aw_addr_r == `FTWAC_A_STAT && w_strb_r[0]) begin
        stat_r <= (stat_r & ~w_data_r[4:0]) | ev;
      end else begin
        stat_r <= stat_r | ev;
      end
      irq <= |(stat_r & mask_r);
    end
  end

  // The read address is decoded at its handshake edge; data then stands
  // with rvalid until the master takes it. Unmapped offsets read zero
  // and answer with an error.
  // AXI4-Lite read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `FTWAC_AXI_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `FTWAC_AXI_OKAY;
        case (s_axi_araddr)
          `FTWAC_A_CTRL: s_axi_rdata <= {29'h0, ctrl_r};
          `FTWAC_A_TAGS: s_axi_rdata <= {13'h0, top_r, tags_r};
          `FTWAC_A_STAT: s_axi_rdata <= {27'h0, stat_r};
          `FTWAC_A_MASK: s_axi_rdata <= {27'h0, mask_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FTWAC_AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ftwac_tag_alias
`default_nettype wire

//--- common/ftwac_consts.vh
// Constants for the shared tag word and SIMD alias control block.
// Assumes inclusion by bare name from design and verification files.
`ifndef FTWAC_CONSTS_VH
`define FTWAC_CONSTS_VH
// Tag encodings
`define FTWAC_TAG_VALID 2'h0
`define FTWAC_TAG_ZERO 2'h1
`define FTWAC_TAG_SPECIAL 2'h2
`define FTWAC_TAG_EMPTY 2'h3
// Reset values
`define FTWAC_TAGS_RST 16'hFFFF
`define FTWAC_TOP_RST 3'h0
// Register image fields
`define FTWAC_EXP_HI 79
`define FTWAC_EXP_LO 64
`define FTWAC_MANT_HI 63
`define FTWAC_EXP_ONES 16'hFFFF
// Exception codes on the fault port
`define FTWAC_EXC_NONE 3'h0
`define FTWAC_EXC_UD 3'h1
`define FTWAC_EXC_NM 3'h2
`define FTWAC_EXC_MF 3'h3
`define FTWAC_EXC_MEM 3'h4
// Operation codes on the command port
`define FTWAC_OP_SIMD 4'h0
`define FTWAC_OP_CLEAR 4'h1
`define FTWAC_OP_FP 4'h2
`define FTWAC_OP_SAVE 4'h3
`define FTWAC_OP_SAVE_NW 4'h4
`define FTWAC_OP_ENV_ST 4'h5
`define FTWAC_OP_XSAVE 4'h6
`define FTWAC_OP_RESTORE 4'h7
`define FTWAC_OP_ENV_LD 4'h8
`define FTWAC_OP_XRESTORE 4'h9
// AXI4-Lite register offsets
`define FTWAC_A_CTRL 4'h0
`define FTWAC_A_TAGS 4'h4
`define FTWAC_A_STAT 4'h8
`define FTWAC_A_MASK 4'hC
// Control register fields
`define FTWAC_CTRL_EM 0
`define FTWAC_CTRL_TS 1
`define FTWAC_CTRL_AC 2
// Status bits: 0 ud, 1 nm, 2 mf, 3 mem fault, 4 save done
`define FTWAC_ST_W 5
`define FTWAC_AXI_OKAY 2'h0
`define FTWAC_AXI_SLVERR 2'h2
`endif

//--- dv/ftwac_chk_sva.sv
// Checker for the tag word block, watching top-level ports only.
// Assumes clk_en is held high while it watches.
`timescale 1ns/1ps
`default_nettype none
`include "ftwac_consts.vh"
module ftwac_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command side
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [2:0] cmd_simd_reg,
  input wire logic [63:0] cmd_simd_data,
  input wire logic fp_err_pending,
  // Results
  input wire logic cmd_done,
  input wire logic [2:0] cmd_exc,
  input wire logic fp_flags_touch,
  input wire logic mem_tag_we,
  input wire logic [15:0] mem_tag_out,
  input wire logic [15:0] live_tags,
  input wire logic [2:0] stack_top,
  input wire logic reg_wr_en,
  input wire logic [2:0] reg_wr_idx,
  input wire logic [79:0] reg_wr_data
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answer without exception
  wire logic ok = cmd_done && cmd_exc == `FTWAC_EXC_NONE;
  a_simd_tags_valid: assert property (ok && $past(cmd_op) == `FTWAC_OP_SIMD
    |=> live_tags == 16'h0000 && stack_top == 3'h0) else $error("simd tags not valid");
  a_clear_tags_empty: assert property (ok && $past(cmd_op) == `FTWAC_OP_CLEAR
    |=> live_tags == 16'hFFFF && stack_top == 3'h0) else $error("clear tags not empty");
  a_save_then_empty: assert property (ok && $past(cmd_op) >= `FTWAC_OP_SAVE
    && $past(cmd_op) <= `FTWAC_OP_XSAVE |-> mem_tag_we ##1 live_tags == 16'hFFFF)
    else $error("save image or empty tags missing");
  a_simd_no_flags: assert property (cmd_valid && cmd_op <= `FTWAC_OP_CLEAR
    |=> !fp_flags_touch) else $error("simd op touched flags");
  a_pending_err_first: assert property (cmd_valid && cmd_op == `FTWAC_OP_SIMD
    && fp_err_pending |=> cmd_done && cmd_exc inside {`FTWAC_EXC_UD, `FTWAC_EXC_NM,
    `FTWAC_EXC_MF}) else $error("pending error not raised");
  a_alias_write: assert property (reg_wr_en |-> reg_wr_idx == $past(cmd_simd_reg)
    && reg_wr_data == {16'hFFFF, $past(cmd_simd_data)}) else $error("alias write wrong");
  a_exc_no_effect: assert property (cmd_done && cmd_exc != `FTWAC_EXC_NONE
    |-> !reg_wr_en ##1 $stable(live_tags)) else $error("faulted op changed state");
  a_image_held: assert property (!mem_tag_we |-> $stable(mem_tag_out))
    else $error("image changed without write");
  a_restore_no_image: assert property (cmd_valid && cmd_op >= `FTWAC_OP_RESTORE
    |=> !mem_tag_we) else $error("restore wrote image");
endmodule // ftwac_chk
bind ftwac_tag_alias ftwac_chk u_chk (.*);
`default_nettype wire

//--- dv/ftwac_mem_model.sv
// Memory model holding the saved tag image.
// Assumes the block writes the image only on its write pulse.
`timescale 1ns/1ps
`default_nettype none
module ftwac_mem_model (
  // Clock
  input wire logic aclk,
  // Image port
  input wire logic mem_tag_we,
  input wire logic [15:0] mem_tag_out,
  output logic [15:0] mem_tag_in
);
  // Memory has no reset: arbitrary power-up pattern
  initial mem_tag_in = 16'h5A5A;
  // Store on write pulse only
  always @(posedge aclk) begin
    if (mem_tag_we) begin
      mem_tag_in <= mem_tag_out;
    end
  end
endmodule // ftwac_mem_model
`default_nettype wire

//--- dv/ftwac_tag_alias_test.sv
// Bench for the tag word block: command scenarios and register access.
// Assumes the memory model and the bound checker beside it.
`timescale 1ns/1ps
`default_nettype none
`include "ftwac_consts.vh"
module ftwac_tag_alias_test;
  // Design-facing signals, named as the ports
  logic aclk, aresetn, clk_en, cmd_valid, cmd_simd_wr, cmd_mem_fault, cmd_misaligned;
  logic fp_err_pending, fp_flags_in_use, cmd_done, fp_flags_touch, mem_tag_we, irq;
  logic state_save_req, state_load_req, vec_state_req, reg_wr_en;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] cmd_op, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [7:0] cmd_mod_mask, cmd_mod_empty;
  logic [2:0] cmd_simd_reg, cmd_exc, stack_top, reg_wr_idx;
  logic [63:0] cmd_simd_data;
  logic [639:0] fp_reg_val;
  logic [79:0] reg_wr_data;
  logic [15:0] mem_tag_in, mem_tag_out, live_tags;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, wd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [8:0] caps; // Answer flags of the last op
  logic [8:0] exc_tab [7]; // ctrl, pending, fault, misaligned, code
  int miscompares, cmp_count;
  localparam logic [79:0] nrm_val = 80'h3FFF8000000000000000; // Plain nonzero
  ftwac_tag_alias dut (.*);
  ftwac_mem_model u_mem (.aclk(aclk), .mem_tag_we(mem_tag_we), .mem_tag_out(mem_tag_out),
    .mem_tag_in(mem_tag_in));
  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Exhausted wait counts as a mismatch
  task automatic hang;
    miscompares++;
    report_and_stop;
  endtask
  // One op; waits for its answer, then one more cycle for the tag copy
  task automatic issue(input logic [3:0] op);
    int n;
    @(posedge aclk);
    cmd_op <= op;
    cmd_valid <= 1'b1;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    #1;
    for (n = 0; n < 20 && cmd_done !== 1'b1; n++) begin
      @(posedge aclk);
      #1;
    end
    if (n == 20) hang();
    caps = {cmd_exc, mem_tag_we, state_save_req, state_load_req, vec_state_req, reg_wr_en,
      fp_flags_touch};
    wd = {1'b0, reg_wr_idx, reg_wr_data[79:64], reg_wr_data[11:0]};
    @(posedge aclk);
    #1;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (n == 50) hang();
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    if (n == 50) hang();
  endtask
  task automatic t_reset;
    chk("tags", live_tags, 16'hFFFF);
    axi_rd(`FTWAC_A_TAGS);
    chk("tags_reg", rd, 32'h0000FFFF);
    axi_wr(`FTWAC_A_TAGS, 32'h0);
    chk("ro_resp", rs, `FTWAC_AXI_SLVERR);
    axi_rd(4'h2);
    chk("unmapped", rs, `FTWAC_AXI_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_simd;
    @(posedge aclk);
    cmd_simd_wr <= 1'b1;
    cmd_simd_reg <= 3'h5;
    cmd_simd_data <= 64'h0123456789ABCDEF;
    fp_flags_in_use <= 1'b1;
    issue(`FTWAC_OP_SIMD);
    chk("simd_caps", caps, 9'h002);
    chk("simd_wr", wd, {1'b0, 3'h5, 16'hFFFF, 12'hDEF});
    chk("simd_tags", live_tags, 16'h0000);
    chk("simd_top", stack_top, 3'h0);
    chk("img_kept", mem_tag_in, 16'h5A5A);
    $display("test simd done");
  endtask
  task automatic t_clr_fp;
    @(posedge aclk);
    cmd_simd_wr <= 1'b0;
    fp_flags_in_use <= 1'b0;
    issue(`FTWAC_OP_CLEAR);
    chk("clr_tags", live_tags, 16'hFFFF);
    @(posedge aclk);
    cmd_mod_mask <= 8'h05;
    cmd_mod_empty <= 8'h04;
    fp_flags_in_use <= 1'b1;
    issue(`FTWAC_OP_FP);
    chk("fp_tags", live_tags, 16'hFFFC);
    chk("fp_touch", caps[0], 1'b1);
    $display("test clear and fp done");
  endtask
  task automatic t_save;
    int i;
    @(posedge aclk);
    cmd_mod_mask <= 8'h80;
    cmd_mod_empty <= 8'h80;
    for (i = 3; i <= 6; i++) begin
      issue(`FTWAC_OP_SIMD);
      issue(`FTWAC_OP_FP);
      issue(i[3:0]);
      chk("save_caps", caps[8:1], {3'h0, 1'b1, i != 5, 1'b0, i == 6, 1'b0});
      chk("save_img", mem_tag_in, 16'hC2A4);
      chk("save_tags", live_tags, 16'hFFFF);
    end
    $display("test save done");
  endtask
  task automatic t_restore;
    int i;
    @(posedge aclk);
    fp_reg_val[79:0] <= 80'h0;
    for (i = 7; i <= 9; i++) begin
      issue(`FTWAC_OP_SIMD);
      issue(i[3:0]);
      chk("rst_caps", caps[8:1], {3'h0, 1'b0, 1'b0, i != 8, i == 9, 1'b0});
      chk("rst_tags", live_tags, 16'hC2A5);
      chk("rst_img", mem_tag_in, 16'hC2A4);
    end
    $display("test restore done");
  endtask
  task automatic t_exc;
    int i;
    for (i = 0; i < 7; i++) begin
      axi_wr(`FTWAC_A_CTRL, 32'h0);
      issue(`FTWAC_OP_CLEAR);
      axi_wr(`FTWAC_A_CTRL, {29'h0, exc_tab[i][8:6]});
      @(posedge aclk);
      {fp_err_pending, cmd_mem_fault, cmd_misaligned} <= exc_tab[i][5:3];
      issue(`FTWAC_OP_SIMD);
      chk("exc", caps[8:6], exc_tab[i][2:0]);
      chk("exc_tags", live_tags, (exc_tab[i][2:0] != 3'h0) ? 16'hFFFF : 16'h0000);
    end
    @(posedge aclk);
    {fp_err_pending, cmd_mem_fault, cmd_misaligned} <= 3'h0;
    $display("test exceptions done");
  endtask
  task automatic t_irq;
    axi_rd(`FTWAC_A_STAT);
    chk("stat", rd, 32'h0000001F);
    chk("irq_masked", irq, 1'b0);
    axi_wr(`FTWAC_A_MASK, 32'h00000002);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq_on", irq, 1'b1);
    axi_wr(`FTWAC_A_STAT, 32'h00000002);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq_off", irq, 1'b0);
    axi_rd(`FTWAC_A_STAT);
    chk("stat_w1c", rd, 32'h0000001D);
    $display("test interrupt done");
  endtask
  // Enable low: a command must not be taken nor the tags move
  task automatic t_freeze;
    @(posedge aclk);
    clk_en <= 1'b0;
    cmd_op <= `FTWAC_OP_CLEAR;
    cmd_valid <= 1'b1;
    repeat (3) @(posedge aclk);
    cmd_valid <= 1'b0;
    clk_en <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk("frz_done", cmd_done, 1'b0);
    chk("frz_tags", live_tags, 16'h0000);
    $display("test freeze done");
  endtask
  // Main sequence: reset, then every scenario in turn
  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    {cmd_valid, cmd_simd_wr, cmd_mem_fault, cmd_misaligned, fp_err_pending} = '0;
    {fp_flags_in_use, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, cmd_op, cmd_mod_mask, cmd_mod_empty} = '0;
    {cmd_simd_reg, cmd_simd_data, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    fp_reg_val = {nrm_val, nrm_val, nrm_val, 80'h3FFF0000000000000000,
      80'h00000000000000000001, 80'hFFFFC000000000000000, 80'h0, nrm_val};
    exc_tab = '{9'h0C1, 9'h0A2, 9'h023, 9'h014, 9'h10C, 9'h008, 9'h000};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    t_reset;
    t_simd;
    t_clr_fp;
    t_save;
    t_restore;
    t_exc;
    t_irq;
    t_freeze;
    report_and_stop;
  end
endmodule // ftwac_tag_alias_test
`default_nettype wire
